// ### rops_pkg.sv
package rops_pkg;
  // ==========================================
  // Register map (byte addresses, chosen)
  // ==========================================
  localparam int ROPS_NUM_REGS = 7;
  localparam int ROPS_NUM_OUTS = 14;
  localparam int ROPS_SEL_W = 6;
  localparam int ROPS_NUM_FUNCS = 64;
  localparam logic [7:0] ROPS_OFS_REG_16 = 8'h00;
  localparam logic [7:0] ROPS_OFS_REG_17 = 8'h04;
  localparam logic [7:0] ROPS_OFS_REG_18 = 8'h08;
  localparam logic [7:0] ROPS_OFS_REG_19 = 8'h0C;
  localparam logic [7:0] ROPS_OFS_REG_20 = 8'h10;
  localparam logic [7:0] ROPS_OFS_REG_21 = 8'h14;
  localparam logic [7:0] ROPS_OFS_REG_22 = 8'h18;
  localparam logic [7:0] ROPS_OFS_STATUS = 8'h1C;
  // ==========================================
  // Field layout
  // ==========================================
  localparam int ROPS_HI_LSB = 8;
  localparam int ROPS_LO_LSB = 0;
  localparam logic [15:0] ROPS_IMPL_MASK = 16'h3F3F;
  localparam logic [15:0] ROPS_RESET_VAL = 16'h0000;
  localparam logic [5:0] ROPS_SEL_PORT = 6'h00;
  localparam logic [1:0] ROPS_RESP_OKAY = 2'h0;
  localparam logic [1:0] ROPS_RESP_SLVERR = 2'h2;
endpackage : rops_pkg

// ### rops_sel_if.sv
`timescale 1ns/1ps
interface rops_sel_if;
  logic [5:0] sel;
  logic sel_valid;
  modport src (output sel, input sel_valid);
  modport mux (input sel, output sel_valid);
endinterface : rops_sel_if

// ### rops_out_mux.sv
`timescale 1ns/1ps
module rops_out_mux
  import rops_pkg::*;
(
  // Select
  rops_sel_if.mux sel_if,
  input wire logic [ROPS_NUM_FUNCS-1:0] func_out,
  input wire logic [ROPS_NUM_FUNCS-1:0] func_present,
  // Port latch path
  input wire logic lat_out,
  input wire logic lat_oe,
  output logic pin_out,
  output logic pin_oe
);
  wire logic sel_hit;
  assign sel_hit = (sel_if.sel != ROPS_SEL_PORT) && func_present[sel_if.sel];
  assign sel_if.sel_valid = sel_hit;
  // Unmapped codes fall back to the port logic
  assign pin_out = sel_hit ? func_out[sel_if.sel] : lat_out;
  assign pin_oe = sel_hit ? 1'b1 : lat_oe;
endmodule : rops_out_mux

// ### rops_top.sv
// Chosen here: the AXI4-Lite slave port and the placing of the registers.
`timescale 1ns/1ps
// Behaviour
// - six-bit function select per remappable output
// - high pin select in bits 13:8
// - low pin select in bits 5:0
// - bits 15:14, 7:6 read zero, ignore writes
// - selects read/write, cleared at reset
// - outputs 170-175 drive virtual ports only
module rops_top
  import rops_pkg::*;
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Peripheral functions
  input wire logic [ROPS_NUM_FUNCS-1:0] func_out,
  input wire logic [ROPS_NUM_FUNCS-1:0] func_present,
  // Port latch path for pins 64..71
  input wire logic [7:0] lat_out,
  input wire logic [7:0] lat_oe,
  // Physical pins 64..71
  output logic [7:0] pin_out,
  output logic [7:0] pin_oe,
  // Virtual ports 170..175
  output logic [5:0] virt_out
);
  // ==========================================
  // Write channel
  // ==========================================
  logic [7:0] awaddr_reg;
  logic aw_held_reg;
  logic [31:0] wdata_reg;
  logic [3:0] wstrb_reg;
  logic w_held_reg;
  logic bvalid_reg;
  logic [1:0] bresp_reg;
  logic [15:0] sel_reg [ROPS_NUM_REGS];
  wire logic do_write;
  wire logic [2:0] wr_idx;
  wire logic wr_hit;
  wire logic [15:0] wr_mask;

  assign s_axi_awready = !aw_held_reg && !bvalid_reg;
  assign s_axi_wready = !w_held_reg && !bvalid_reg;
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;
  assign do_write = aw_held_reg && w_held_reg && !bvalid_reg;
  assign wr_idx = awaddr_reg[4:2];
  assign wr_hit = (awaddr_reg[1:0] == 2'h0) && (awaddr_reg[7:5] == 3'h0) && (wr_idx < 3'(ROPS_NUM_REGS));
  assign wr_mask = {{8{wstrb_reg[1]}}, {8{wstrb_reg[0]}}} & ROPS_IMPL_MASK;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_reg <= 1'b0;
      awaddr_reg <= 8'h00;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held_reg <= 1'b1;
      awaddr_reg <= s_axi_awaddr;
    end else if (do_write) begin
      aw_held_reg <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held_reg <= 1'b0;
      wdata_reg <= 32'h00000000;
      wstrb_reg <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held_reg <= 1'b1;
      wdata_reg <= s_axi_wdata;
      wstrb_reg <= s_axi_wstrb;
    end else if (do_write) begin
      w_held_reg <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_reg <= 1'b0;
      bresp_reg <= ROPS_RESP_OKAY;
    end else if (do_write) begin
      bvalid_reg <= 1'b1;
      bresp_reg <= wr_hit ? ROPS_RESP_OKAY : ROPS_RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_reg <= 1'b0;
    end
  end

  // ==========================================
  // Select registers
  // ==========================================
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int i = 0; i < ROPS_NUM_REGS; i++) begin
        sel_reg[i] <= ROPS_RESET_VAL;
      end
    end else if (do_write && wr_hit) begin
      sel_reg[wr_idx] <= (sel_reg[wr_idx] & ~wr_mask) | (wdata_reg[15:0] & wr_mask);
    end
  end

  // ==========================================
  // Read channel
  // ==========================================
  logic rvalid_reg;
  logic [31:0] rdata_reg;
  logic [1:0] rresp_reg;
  logic rd_was_sel_reg;
  wire logic [2:0] rd_idx;
  wire logic rd_sel_hit;
  wire logic rd_stat_hit;
  wire logic [13:0] active_map;
  wire logic [31:0] rd_value;

  assign s_axi_arready = !rvalid_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rdata = rdata_reg;
  assign s_axi_rresp = rresp_reg;
  assign rd_idx = s_axi_araddr[4:2];
  assign rd_sel_hit = (s_axi_araddr[1:0] == 2'h0) && (s_axi_araddr[7:5] == 3'h0)
    && (rd_idx < 3'(ROPS_NUM_REGS));
  assign rd_stat_hit = (s_axi_araddr == ROPS_OFS_STATUS);
  assign rd_value = rd_sel_hit ? {16'h0000, sel_reg[rd_idx] & ROPS_IMPL_MASK}
    : rd_stat_hit ? {18'h00000, active_map} : 32'h00000000;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h00000000;
      rresp_reg <= ROPS_RESP_OKAY;
      rd_was_sel_reg <= 1'b0;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rvalid_reg <= 1'b1;
      rdata_reg <= rd_value;
      rd_was_sel_reg <= rd_sel_hit;
      rresp_reg <= (rd_sel_hit || rd_stat_hit) ? ROPS_RESP_OKAY : ROPS_RESP_SLVERR;
    end else if (s_axi_rready) begin
      rvalid_reg <= 1'b0;
    end
  end

  // ==========================================
  // Output routing
  // ==========================================
  rops_sel_if sel_bus [ROPS_NUM_OUTS] ();
  wire logic [13:0] mux_out;
  wire logic [13:0] mux_oe;
  wire logic [13:0] lat_out_all;
  wire logic [13:0] lat_oe_all;

  // Virtual ports have no latch path and idle low
  assign lat_out_all = {6'h00, lat_out};
  assign lat_oe_all = {6'h00, lat_oe};

  for (genvar g = 0; g < ROPS_NUM_OUTS; g++) begin : g_out
    // Even outputs take bits 5:0, odd ones bits 13:8
    if (g % 2 == 0) begin : g_lo
      assign sel_bus[g].sel = sel_reg[g / 2][ROPS_LO_LSB +: ROPS_SEL_W];
    end else begin : g_hi
      assign sel_bus[g].sel = sel_reg[g / 2][ROPS_HI_LSB +: ROPS_SEL_W];
    end
    assign active_map[g] = sel_bus[g].sel_valid;
    rops_out_mux u_mux (
      .sel_if(sel_bus[g]),
      .func_out(func_out),
      .func_present(func_present),
      .lat_out(lat_out_all[g]),
      .lat_oe(lat_oe_all[g]),
      .pin_out(mux_out[g]),
      .pin_oe(mux_oe[g])
    );
  end

  assign pin_out = mux_out[7:0];
  assign pin_oe = mux_oe[7:0];
  assign virt_out = mux_out[13:8];

  // ==========================================
  // Checks
  // ==========================================
  a_reserved_zero: assert property (@(posedge aclk) disable iff (!aresetn)
    (rvalid_reg && rd_was_sel_reg) |-> (rdata_reg[15:14] == 2'h0 && rdata_reg[7:6] == 2'h0))
    else $error("reserved select bits read nonzero");
  a_write_lands: assert property (@(posedge aclk) disable iff (!aresetn)
    (do_write && wr_hit && wr_idx == 3'h0 && wstrb_reg[0]) |=> (sel_reg[0][5:0] == $past(wdata_reg[5:0])))
    else $error("write did not update low select");
  a_hi_field_route: assert property (@(posedge aclk) disable iff (!aresetn)
    (sel_reg[0][13:8] == 6'h00) |-> (pin_out[1] == lat_out[1] && pin_oe[1] == lat_oe[1]))
    else $error("pin 65 not under port control");
  a_lo_field_route: assert property (@(posedge aclk) disable iff (!aresetn)
    (sel_reg[0][5:0] != 6'h00 && func_present[sel_reg[0][5:0]]) |-> (pin_out[0] == func_out[sel_reg[0][5:0]]))
    else $error("pin 64 not driven by selected function");
  a_unmapped_port: assert property (@(posedge aclk) disable iff (!aresetn)
    (!func_present[sel_reg[3][13:8]]) |-> (pin_oe[7] == lat_oe[7]))
    else $error("unmapped code took pin 71");
  a_virtual_route: assert property (@(posedge aclk) disable iff (!aresetn)
    (sel_reg[6][13:8] != 6'h00 && func_present[sel_reg[6][13:8]]) |-> (virt_out[5] == func_out[sel_reg[6][13:8]]))
    else $error("virtual 175 misrouted");
  a_sel_width: assert property (@(posedge aclk) disable iff (!aresetn)
    (sel_reg[2][5:0] == 6'h00) |-> !active_map[4])
    else $error("zero select reported active");
  a_reset_clear: assert property (@(posedge aclk)
    !aresetn |=> (sel_reg[4] == 16'h0000 && sel_reg[6] == 16'h0000))
    else $error("select not cleared by reset");
  a_resp_one: assert property (@(posedge aclk) disable iff (!aresetn)
    do_write |=> bvalid_reg ##0 !aw_held_reg)
    else $error("write response missing");

  // ==========================================
  // Handshake and routing checks
  // ==========================================
  wire logic [16*ROPS_NUM_REGS-1:0] sel_flat;
  assign sel_flat = {sel_reg[6], sel_reg[5], sel_reg[4], sel_reg[3], sel_reg[2], sel_reg[1], sel_reg[0]};

  a_aw_once: assert property (@(posedge aclk) disable iff (!aresetn)
    (s_axi_awvalid && s_axi_awready) |=> !s_axi_awready)
    else $error("write address taken twice");
  a_w_once: assert property (@(posedge aclk) disable iff (!aresetn)
    (s_axi_wvalid && s_axi_wready) |=> !s_axi_wready)
    else $error("write data taken twice");
  a_ar_once: assert property (@(posedge aclk) disable iff (!aresetn)
    (s_axi_arvalid && s_axi_arready) |=> !s_axi_arready)
    else $error("read address taken twice");
  a_write_answer: assert property (@(posedge aclk) disable iff (!aresetn)
    (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready) |-> ##2 s_axi_bvalid)
    else $error("write answer late");
  a_read_answer: assert property (@(posedge aclk) disable iff (!aresetn)
    (s_axi_arvalid && s_axi_arready) |=> s_axi_rvalid)
    else $error("read answer late");
  a_bvalid_hold: assert property (@(posedge aclk) disable iff (!aresetn)
    (s_axi_bvalid && !s_axi_bready) |=> (s_axi_bvalid && $stable(s_axi_bresp)))
    else $error("write response dropped early");
  a_rvalid_hold: assert property (@(posedge aclk) disable iff (!aresetn)
    (s_axi_rvalid && !s_axi_rready) |=> (s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp)))
    else $error("read response dropped early");
  a_write_refused: assert property (@(posedge aclk) disable iff (!aresetn)
    (do_write && !wr_hit) |=> (s_axi_bresp == ROPS_RESP_SLVERR && $stable(sel_flat)))
    else $error("refused write had an effect");
  a_write_okay: assert property (@(posedge aclk) disable iff (!aresetn)
    (do_write && wr_hit) |=> (s_axi_bresp == ROPS_RESP_OKAY))
    else $error("mapped write not acknowledged");
  a_read_refused: assert property (@(posedge aclk) disable iff (!aresetn)
    (s_axi_arvalid && s_axi_arready && !rd_sel_hit && !rd_stat_hit)
    |=> (s_axi_rresp == ROPS_RESP_SLVERR && s_axi_rdata == 32'h00000000))
    else $error("unmapped read not refused");
  a_status_read: assert property (@(posedge aclk) disable iff (!aresetn)
    (s_axi_arvalid && s_axi_arready && rd_stat_hit) |=> (s_axi_rresp == ROPS_RESP_OKAY && s_axi_rdata[31:14] == 18'h0))
    else $error("status read malformed");
  a_read_back: assert property (@(posedge aclk) disable iff (!aresetn)
    (s_axi_arvalid && s_axi_arready && rd_sel_hit && rd_idx == 3'h1) |=> (s_axi_rdata == {16'h0000, $past(sel_reg[1])}))
    else $error("select read back wrong");
  a_reserved_store: assert property (@(posedge aclk) disable iff (!aresetn)
    (sel_flat & {ROPS_NUM_REGS{~ROPS_IMPL_MASK}}) == '0)
    else $error("reserved select bits stored");
  a_lo_strobe_keep: assert property (@(posedge aclk) disable iff (!aresetn)
    (do_write && wr_hit && wr_idx == 3'h2 && !wstrb_reg[0]) |=> $stable(sel_reg[2][5:0]))
    else $error("unstrobed low select changed");
  a_hi_write_lands: assert property (@(posedge aclk) disable iff (!aresetn)
    (do_write && wr_hit && wr_idx == 3'h5 && wstrb_reg[1]) |=> (sel_reg[5][13:8] == $past(wdata_reg[13:8])))
    else $error("write did not update high select");
  a_hi_strobe_keep: assert property (@(posedge aclk) disable iff (!aresetn)
    (do_write && wr_hit && wr_idx == 3'h3 && !wstrb_reg[1]) |=> $stable(sel_reg[3][13:8]))
    else $error("unstrobed high select changed");
  a_pin_oe_taken: assert property (@(posedge aclk) disable iff (!aresetn)
    (sel_reg[1][5:0] != 6'h00 && func_present[sel_reg[1][5:0]]) |-> pin_oe[2])
    else $error("pin 66 not driven by function");
  a_pin_hi_route: assert property (@(posedge aclk) disable iff (!aresetn)
    (sel_reg[3][13:8] != 6'h00 && func_present[sel_reg[3][13:8]]) |-> (pin_out[7] == func_out[sel_reg[3][13:8]]))
    else $error("pin 71 misrouted");
  a_pin_mid_route: assert property (@(posedge aclk) disable iff (!aresetn)
    (sel_reg[2][13:8] != 6'h00 && func_present[sel_reg[2][13:8]]) |-> (pin_out[5] == func_out[sel_reg[2][13:8]]))
    else $error("pin 69 misrouted");
  a_zero_port: assert property (@(posedge aclk) disable iff (!aresetn)
    (sel_reg[2][5:0] == 6'h00) |-> (pin_out[4] == lat_out[4] && pin_oe[4] == lat_oe[4]))
    else $error("pin 68 not under port control");
  a_virt_idle: assert property (@(posedge aclk) disable iff (!aresetn)
    (sel_reg[4][5:0] == 6'h00) |-> !virt_out[0])
    else $error("virtual 170 not idle");
  a_virt_lo_route: assert property (@(posedge aclk) disable iff (!aresetn)
    (sel_reg[5][5:0] != 6'h00 && func_present[sel_reg[5][5:0]]) |-> (virt_out[2] == func_out[sel_reg[5][5:0]]))
    else $error("virtual 172 misrouted");
  a_virt_absent: assert property (@(posedge aclk) disable iff (!aresetn)
    !func_present[sel_reg[5][13:8]] |-> !virt_out[3])
    else $error("virtual 173 driven by absent code");
  a_status_virt: assert property (@(posedge aclk) disable iff (!aresetn)
    active_map[13] == (sel_reg[6][13:8] != 6'h00 && func_present[sel_reg[6][13:8]]))
    else $error("status bit of virtual 175 wrong");
  a_reset_quiet: assert property (@(posedge aclk)
    !aresetn |=> (!s_axi_bvalid && !s_axi_rvalid && sel_reg[1] == 16'h0000))
    else $error("reset left the bus or selects busy");
endmodule : rops_top

// ### rops_periph_model.sv
`timescale 1ns/1ps
module rops_periph_model (
  // Clock
  input wire logic aclk,
  // Peripheral functions and port latch
  output logic [63:0] func_out,
  output logic [63:0] func_present,
  output logic [7:0] lat_out,
  output logic [7:0] lat_oe
);
  logic [63:0] fn_q = 64'h0123_4567_89AB_CDEF;
  logic [7:0] lo_q = 8'h5A;
  logic [7:0] le_q = 8'hC3;
  // Codes 0 and 40 have no peripheral behind them
  assign func_present = 64'hFFFF_FEFF_FFFF_FFFE;
  assign func_out = fn_q;
  assign lat_out = lo_q;
  assign lat_oe = le_q;
  // Function outputs and latch values move each cycle so a stale route shows; func_present stays fixed
  always @(posedge aclk) begin
    fn_q <= {fn_q[62:0], fn_q[63] ^ fn_q[60]};
    lo_q <= ~lo_q ^ fn_q[7:0];
    le_q <= le_q + 8'h35;
  end
endmodule : rops_periph_model

// ### rops_tb_top.sv
`timescale 1ns/1ps
module tb_top;
  import rops_pkg::*;
  logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic [7:0] awaddr, araddr, pin_out, pin_oe, lat_out, lat_oe;
  logic [31:0] wdata, rdata, d;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, r;
  logic [5:0] virt_out;
  logic [63:0] func_out, func_present;
  int fails, total_checks, cycles, i;
  int mdl [7];
  logic [15:0] m;
  logic [3:0] s;
  logic [7:0] bad [3] = '{8'h1C, 8'h20, 8'h02};
  rops_top rops_top_inst (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .func_out(func_out),
    .func_present(func_present), .lat_out(lat_out), .lat_oe(lat_oe), .pin_out(pin_out),
    .pin_oe(pin_oe), .virt_out(virt_out));
  rops_periph_model rops_periph_model_inst (.aclk(aclk), .func_out(func_out), .func_present(func_present),
    .lat_out(lat_out), .lat_oe(lat_oe));
  // ==========================================
  // Clock, timeout, checks
  // ==========================================
  initial begin
    aclk = 1'b0;
    forever #25 aclk = ~aclk;
  end
  always @(posedge aclk) begin
    cycles++;
    if (cycles == 20000) begin
      fails++;
      end_sim();
    end
  end
  task automatic cmp_val(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask : cmp_val
  // Expected pins from the model; looked at mid-cycle, then back to a rising edge
  task automatic cmp_pins();
    int c;
    logic v;
    logic [21:0] e;
    @(negedge aclk);
    for (int n = 0; n < 14; n++) begin
      c = (mdl[n / 2] >> (8 * (n % 2))) & 63;
      v = (c != 0) && (func_present[c] === 1'b1);
      if (n < 8) begin
        e[14 + n] = v ? func_out[c] : lat_out[n];
        e[6 + n] = v ? 1'b1 : lat_oe[n];
      end else begin
        e[n - 8] = v ? func_out[c] : 1'b0;
      end
    end
    cmp_val({10'h000, pin_out, pin_oe, virt_out}, {10'h000, e});
    @(posedge aclk);
  endtask : cmp_pins
  // Status bit n is set when output n routes a present function
  function automatic logic [31:0] exp_active();
    int c;
    exp_active = 32'h0;
    for (int n = 0; n < 14; n++) begin
      c = (mdl[n / 2] >> (8 * (n % 2))) & 63;
      exp_active[n] = (c != 0) && (func_present[c] === 1'b1);
    end
  endfunction : exp_active
  // ==========================================
  // AXI4-Lite master
  // ==========================================
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] wd, input logic [3:0] ws, output logic [1:0] wr);
    awaddr <= a;
    wdata <= wd;
    wstrb <= ws;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    wr = bresp;
  endtask : axi_wr
  task automatic axi_rd(input logic [7:0] a, output logic [31:0] rd, output logic [1:0] rr);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready === 1'b1) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    rd = rdata;
    rr = rresp;
  endtask : axi_rd
  task automatic end_sim();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : end_sim
  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready, awaddr, araddr, wstrb, wdata} = '0;
    {fails, total_checks, cycles} = '0;
    mdl = '{default: 0};
    void'($urandom(32'h1155));
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    for (i = 0; i < 7; i++) begin
      axi_rd(8'(4 * i), d, r);
      cmp_val(d, 32'h0000_0000);
    end
    cmp_pins();
    $display("test reset done");
    // Absent code, zero code and top code first, then random traffic
    for (int k = 0; k < 44; k++) begin
      i = (k == 0) ? 0 : (k == 1) ? 6 : $urandom_range(6, 0);
      d = (k == 0) ? 32'hFFFF_2800 : (k == 1) ? 32'hC0C0_3F01 : $urandom;
      s = (k < 2) ? 4'hF : 4'($urandom);
      axi_wr(8'(4 * i), d, s, r);
      cmp_val(r, ROPS_RESP_OKAY);
      // Strobe lanes 0 and 1 pick the bytes that land
      m = {{8{s[1]}}, {8{s[0]}}} & 16'h3F3F;
      mdl[i] = (mdl[i] & ~m) | (d[15:0] & m);
      axi_rd(8'(4 * i), d, r);
      cmp_val(d, mdl[i]);
      cmp_val(r, ROPS_RESP_OKAY);
      cmp_pins();
      axi_rd(ROPS_OFS_STATUS, d, r);
      cmp_val(d, exp_active());
    end
    $display("test select done");
    for (int j = 0; j < 3; j++) begin
      axi_wr(bad[j], 32'h0000_1515, 4'hF, r);
      cmp_val(r, ROPS_RESP_SLVERR);
    end
    axi_rd(8'h20, d, r);
    cmp_val(d, 32'h0000_0000);
    cmp_val(r, ROPS_RESP_SLVERR);
    for (i = 0; i < 7; i++) begin
      axi_rd(8'(4 * i), d, r);
      cmp_val(d, mdl[i]);
    end
    cmp_pins();
    $display("test refusal done");
    end_sim();
  end
endmodule : tb_top
